//--- slc_pkg.sv
// Package for the serial link channel configuration block
//----------------------------------------------------------------------
// Summary of operation
// R1: One-converter select runs channel A alone
// R2: Software keeps lower pair enabled in single mode
// R3: Upper-pair enable gates channels C and D
// R4: Lower-pair enable gates channels A and B
// R5: Software stops calibration and link before changes
// R6: Software never clears both pair enables
// R7: Halved config: lanes ceil(L/2), converters M/2
// R8: Odd halved lane count pads highest lane
// R9: Lower pair off moves C,D into A,B slots
// R10: Software writes reserved bits as zero
// R11: Sync header select: 0 CRC-12, 2 FEC
// R12: Sync word 32 bits, only in 64B/66B formats
// R13: All command fields sent as zero
// R14: Software changes header select only when link off
// R15: Resync request after threshold+1 low samples
//----------------------------------------------------------------------
package slc_pkg;
  // Register offsets
  localparam logic [11:0] SLC_OFS_CHEN = 12'h209;
  localparam logic [11:0] SLC_OFS_SHSEL = 12'h20f;
  localparam logic [11:0] SLC_OFS_THRESH = 12'h210;
  // Reset values
  localparam logic [7:0] SLC_RST_CHEN = 8'h03;
  localparam logic [7:0] SLC_RST_SHSEL = 8'h00;
  localparam logic [7:0] SLC_RST_THRESH = 8'h03;
  // Field positions and masks
  localparam int SLC_BIT_LOWER = 0;
  localparam int SLC_BIT_UPPER = 1;
  localparam int SLC_BIT_ONE = 2;
  localparam logic [7:0] SLC_MASK_CHEN = 8'h07;
  localparam logic [7:0] SLC_MASK_SHSEL = 8'h03;
  localparam logic [7:0] SLC_MASK_THRESH = 8'h1f;
  // Sync header encodings and sync word size
  localparam logic [1:0] SLC_SH_CRC12 = 2'h0;
  localparam logic [1:0] SLC_SH_FEC = 2'h2;
  localparam int SLC_SYNC_WORD_BITS = 32;
  // Sync header content kinds
  typedef enum logic [1:0] {
    SLC_HDR_NONE = 2'b00,
    SLC_HDR_CRC = 2'b01,
    SLC_HDR_FEC = 2'b10
  } slc_hdr_t;
endpackage

//--- slc_if.sv
// Interface joining the device end and the software end
`timescale 1ns/1ps
interface slc_if;
  logic wr;
  logic rd;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport dev (input wr, input rd, input addr, input wdata,
    output rdata, output rvalid);
  modport host (output wr, output rd, output addr, output wdata,
    input rdata, input rvalid);
endinterface

//--- slc_device.sv
// Device end: channel, lane and sync header configuration
`timescale 1ns/1ps
module slc_device
  import slc_pkg::*;
#(
  parameter int NOM_LANES = 8,
  parameter int NOM_CONV = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  slc_if.dev bus,
  input wire logic i_link_fmt_66b,
  input wire logic i_sync_n,
  output logic [3:0] o_chan_en,
  output logic o_single_mode,
  output logic [7:0] o_lanes,
  output logic [7:0] o_convs,
  output logic o_tail_pad,
  output logic o_swap_pairs,
  output slc_hdr_t o_hdr_kind,
  output logic [7:0] o_sync_word_bits,
  output logic [7:0] o_cmd_field,
  output logic o_resync_req
);
  //--------------------------------------------------------------------
  // Register file
  //--------------------------------------------------------------------
  logic [7:0] chen_r;
  logic [7:0] shsel_r;
  logic [7:0] thresh_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // Writes store only defined bits; reserved bits stay zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      chen_r <= SLC_RST_CHEN;
      shsel_r <= SLC_RST_SHSEL;
      thresh_r <= SLC_RST_THRESH;
    end else if (i_ce && bus.wr) begin
      case (bus.addr)
        SLC_OFS_CHEN: chen_r <= bus.wdata & SLC_MASK_CHEN;
        SLC_OFS_SHSEL: shsel_r <= bus.wdata & SLC_MASK_SHSEL;
        SLC_OFS_THRESH: thresh_r <= bus.wdata & SLC_MASK_THRESH;
        default: ;
      endcase
    end
  end

  // Read answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (i_ce) begin
      rvalid_r <= bus.rd;
      if (bus.rd) begin
        case (bus.addr)
          SLC_OFS_CHEN: rdata_r <= chen_r;
          SLC_OFS_SHSEL: rdata_r <= shsel_r;
          SLC_OFS_THRESH: rdata_r <= thresh_r;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end
  assign bus.rdata = rdata_r;
  assign bus.rvalid = rvalid_r;

  //--------------------------------------------------------------------
  // Channel and link scaling
  //--------------------------------------------------------------------
  logic lower_en;
  logic upper_en;
  logic one_sel;
  logic halved;
  logic [3:0] chan_nxt;
  assign lower_en = chen_r[SLC_BIT_LOWER];
  assign upper_en = chen_r[SLC_BIT_UPPER];
  assign one_sel = chen_r[SLC_BIT_ONE];
  assign halved = !lower_en || !upper_en;

  // Channel map {D,C,B,A}; single mode wins over pair bits
  always_comb begin
    if (one_sel) begin
      chan_nxt = 4'h1; // R1
    end else begin
      chan_nxt = {upper_en, upper_en, lower_en, lower_en}; // R3 R4
    end
  end

  logic [7:0] nom_l;
  logic [7:0] nom_m;
  assign nom_l = 8'(NOM_LANES);
  assign nom_m = 8'(NOM_CONV);

  // Registered outputs so downstream framing sees stable values
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_chan_en <= 4'hf;
      o_single_mode <= 1'b0;
      o_lanes <= nom_l;
      o_convs <= nom_m;
      o_tail_pad <= 1'b0;
      o_swap_pairs <= 1'b0;
    end else if (i_ce) begin
      o_chan_en <= chan_nxt;
      o_single_mode <= one_sel;
      o_lanes <= halved ? 8'((nom_l + 8'h01) >> 1) : nom_l; // R7
      o_convs <= halved ? (nom_m >> 1) : nom_m; // R7
      o_tail_pad <= halved && nom_l[0]; // R8
      o_swap_pairs <= !lower_en && upper_en && !one_sel; // R9
    end
  end

  //--------------------------------------------------------------------
  // Sync header content
  //--------------------------------------------------------------------
  // Reserved codes fall back to no header rather than guess a format
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_hdr_kind <= SLC_HDR_NONE;
      o_sync_word_bits <= 8'h00;
      o_cmd_field <= 8'h00;
    end else if (i_ce) begin
      o_cmd_field <= 8'h00; // R13
      if (!i_link_fmt_66b) begin
        o_hdr_kind <= SLC_HDR_NONE; // R12
        o_sync_word_bits <= 8'h00;
      end else begin
        o_sync_word_bits <= 8'(SLC_SYNC_WORD_BITS); // R12
        case (shsel_r[1:0])
          SLC_SH_CRC12: o_hdr_kind <= SLC_HDR_CRC; // R11
          SLC_SH_FEC: o_hdr_kind <= SLC_HDR_FEC; // R11
          default: o_hdr_kind <= SLC_HDR_NONE;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Resync request filter
  //--------------------------------------------------------------------
  logic sync_m_r;
  logic sync_s_r;
  logic [5:0] low_cnt_r;

  // Sync pin comes from outside; two flops before use
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync_m_r <= 1'b1;
      sync_s_r <= 1'b1;
    end else if (i_ce) begin
      sync_m_r <= i_sync_n;
      sync_s_r <= sync_m_r;
    end
  end

  // Short lows are error reports and are dropped
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      low_cnt_r <= 6'h00;
      o_resync_req <= 1'b0;
    end else if (i_ce) begin
      if (sync_s_r) begin
        low_cnt_r <= 6'h00;
        o_resync_req <= 1'b0;
      end else begin
        if (low_cnt_r <= {1'b0, thresh_r[4:0]}) begin
          low_cnt_r <= low_cnt_r + 6'h01;
        end
        o_resync_req <= (low_cnt_r >= {1'b0, thresh_r[4:0]}); // R15
      end
    end
  end
endmodule

//--- slc_host.sv
// Software end: register access sequencer that keeps the write discipline
`timescale 1ns/1ps
module slc_host
  import slc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  slc_if.host bus,
  input wire logic i_req_wr,
  input wire logic i_req_rd,
  input wire logic [11:0] i_req_addr,
  input wire logic [7:0] i_req_data,
  input wire logic i_link_tx_en,
  input wire logic i_cal_en,
  output logic o_busy,
  output logic o_refused,
  output logic [7:0] o_rdata,
  output logic o_rdone
);
  //--------------------------------------------------------------------
  // Request check and drive
  //--------------------------------------------------------------------
  logic [7:0] wmask;
  logic bad_wr;
  logic wait_r;

  // Reserved bits are forced to zero on every write
  always_comb begin
    case (i_req_addr)
      SLC_OFS_CHEN: wmask = SLC_MASK_CHEN;
      SLC_OFS_SHSEL: wmask = SLC_MASK_SHSEL;
      SLC_OFS_THRESH: wmask = SLC_MASK_THRESH;
      default: wmask = 8'h00;
    endcase
  end

  // Refuse writes that would break link or channel rules
  always_comb begin
    bad_wr = 1'b0;
    if (i_req_addr == SLC_OFS_CHEN) begin
      if (i_link_tx_en || i_cal_en) bad_wr = 1'b1; // R5
      if (!i_req_data[SLC_BIT_LOWER] && !i_req_data[SLC_BIT_UPPER]) begin
        bad_wr = 1'b1; // R6
      end
      if (i_req_data[SLC_BIT_ONE] && !i_req_data[SLC_BIT_LOWER]) begin
        bad_wr = 1'b1; // R2
      end
    end
    if (i_req_addr == SLC_OFS_SHSEL && i_link_tx_en) bad_wr = 1'b1; // R14
  end

  // One access in flight; a read waits for its answer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 12'h000;
      bus.wdata <= 8'h00;
      o_refused <= 1'b0;
      wait_r <= 1'b0;
    end else if (i_ce) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      o_refused <= 1'b0;
      if (wait_r) begin
        if (bus.rvalid) wait_r <= 1'b0;
      end else if (i_req_wr) begin
        if (bad_wr) begin
          o_refused <= 1'b1;
        end else begin
          bus.wr <= 1'b1;
          bus.addr <= i_req_addr;
          bus.wdata <= i_req_data & wmask; // R10
        end
      end else if (i_req_rd) begin
        bus.rd <= 1'b1;
        bus.addr <= i_req_addr;
        wait_r <= 1'b1;
      end
    end
  end
  assign o_busy = wait_r;

  // Capture read answer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      o_rdone <= 1'b0;
    end else if (i_ce) begin
      o_rdone <= bus.rvalid;
      if (bus.rvalid) o_rdata <= bus.rdata;
    end
  end
endmodule

//--- slc_assertions.sv
// Checker for the configuration bus and derived link outputs
`timescale 1ns/1ps
module slc_assertions
  import slc_pkg::*;
#(
  parameter int NOM_LANES = 8,
  parameter int NOM_CONV = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic rd,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rvalid,
  input wire logic [3:0] o_chan_en,
  input wire logic o_single_mode,
  input wire logic [7:0] o_lanes,
  input wire logic [7:0] o_convs,
  input wire logic o_tail_pad,
  input wire logic o_swap_pairs,
  input wire logic [7:0] o_cmd_field
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // A write of one word to the channel enable register
  sequence s_chen_wr(logic [7:0] v);
    wr && addr == SLC_OFS_CHEN && wdata == v;
  endsequence
  // One pair off halves lanes and converters
  sequence s_halved;
    o_chan_en == 4'h3 || o_chan_en == 4'hc;
  endsequence
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_cmd_zero: assert property (o_cmd_field == 8'h00)
    else $error("command field not zero");
  a_single_only: assert property (o_single_mode |-> o_chan_en == 4'h1)
    else $error("single mode enables more than A");
  a_upper_off: assert property (s_chen_wr(8'h01) |-> ##[2:3] o_chan_en == 4'h3)
    else $error("lower pair word not applied");
  a_lower_off: assert property (s_chen_wr(8'h02) |-> ##[2:3] o_chan_en == 4'hc)
    else $error("upper pair word not applied");
  a_halved_count: assert property (s_halved |-> o_lanes == (NOM_LANES + 1) / 2
    && o_convs == NOM_CONV / 2)
    else $error("halved counts wrong");
  a_tail_pad: assert property (s_halved |-> o_tail_pad == NOM_LANES[0])
    else $error("tail padding wrong");
  a_pair_swap: assert property (o_chan_en == 4'hc |-> o_swap_pairs)
    else $error("upper pair not moved into lower slots");
endmodule

//--- serial_link_channel_config_tb.sv
// Self-checking bench joining the device end and the software end
`timescale 1ns/1ps
module serial_link_channel_config_tb
  import slc_pkg::*;
;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, fmt = 0, sync_n = 1;
  logic lnk = 0, cal = 0, ce = 1, single, tail, swap, busy, refd, rdone, rq;
  logic [11:0] ad = 0;
  logic [7:0] wd = 0, lanes, convs, sbits, cmd, rdat;
  logic [3:0] chan;
  slc_hdr_t hdr;
  int errors = 0, compares = 0;
  slc_if bus_if();
  // Free-running system clock
  always #10 clk = ~clk;
  // Odd lane count so the tail padding path is reached
  slc_device #(.NOM_LANES(7), .NOM_CONV(8)) slc_device_i (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .bus(bus_if),
    .i_link_fmt_66b(fmt), .i_sync_n(sync_n), .o_chan_en(chan),
    .o_single_mode(single), .o_lanes(lanes), .o_convs(convs),
    .o_tail_pad(tail), .o_swap_pairs(swap), .o_hdr_kind(hdr),
    .o_sync_word_bits(sbits), .o_cmd_field(cmd), .o_resync_req(rq));
  slc_host slc_host_i (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .bus(bus_if),
    .i_req_wr(wr), .i_req_rd(rd), .i_req_addr(ad), .i_req_data(wd),
    .i_link_tx_en(lnk), .i_cal_en(cal), .o_busy(busy),
    .o_refused(refd), .o_rdata(rdat), .o_rdone(rdone));
  slc_assertions #(.NOM_LANES(7), .NOM_CONV(8)) slc_assertions_i (
    .i_sys_clk(clk), .i_rst_n(rst_n), .rd(bus_if.rd), .wr(bus_if.wr),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rvalid(bus_if.rvalid),
    .o_chan_en(chan), .o_single_mode(single), .o_lanes(lanes),
    .o_convs(convs), .o_tail_pad(tail), .o_swap_pairs(swap),
    .o_cmd_field(cmd));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  logic refd_seen;
  // Host write; refusal is caught over two cycles, outputs then settle
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    logic r;
    @(posedge clk);
    wr <= 1; ad <= a; wd <= d;
    @(posedge clk);
    wr <= 0;
    #1 r = refd;
    @(posedge clk);
    #1 r = r | refd;
    repeat (3) @(posedge clk);
    #1 refd_seen = r;
  endtask
  // Host read, bounded wait for completion
  task automatic get(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1; ad <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk({7'h0, busy}, 8'h01);
    for (int i = 0; i < 8 && rdone !== 1'b1; i++) @(posedge clk) #1;
    // A read that never completes counts as a mismatch here
    chk({7'h0, rdone}, 8'h01);
    chk(rdat, exp);
  endtask
  task automatic t_reset();
    get(SLC_OFS_CHEN, 8'h03);
    get(SLC_OFS_SHSEL, 8'h00);
    get(SLC_OFS_THRESH, 8'h03);
    get(12'h20a, 8'h00);
    chk({4'h0, chan}, 8'hf);
    chk(lanes, 8'h07);
  endtask
  task automatic t_pairs();
    put(SLC_OFS_CHEN, 8'hf9);
    get(SLC_OFS_CHEN, 8'h01);
    chk({tail, swap, 2'h0, chan}, 8'h83);
    chk(convs, 8'h04);
    put(SLC_OFS_CHEN, 8'h02);
    chk({tail, swap, 2'h0, chan}, 8'hcc);
    put(SLC_OFS_CHEN, 8'h07);
    chk({single, 3'h0, chan}, 8'h81);
    put(SLC_OFS_CHEN, 8'h00);
    chk({refd_seen, 3'h0, chan}, 8'h81);
    put(SLC_OFS_CHEN, 8'h06);
    chk({refd_seen, 3'h0, chan}, 8'h81);
    put(SLC_OFS_CHEN, 8'h03);
  endtask
  // Clock enable low freezes both ends; a request then is lost
  task automatic t_freeze();
    @(posedge clk) ce <= 0;
    wr <= 1;
    ad <= SLC_OFS_CHEN;
    wd <= 8'h01;
    @(posedge clk) wr <= 0;
    repeat (4) @(posedge clk);
    #1 chk({3'h0, busy, chan}, 8'h0f);
    @(posedge clk) ce <= 1;
    get(SLC_OFS_CHEN, 8'h03);
    chk(lanes, 8'h07);
  endtask
  // Channel enable writes during link or calibration, and header select writes during link, are held off
  task automatic t_guard();
    @(posedge clk) lnk <= 1;
    put(SLC_OFS_CHEN, 8'h01);
    chk({refd_seen, 3'h0, chan}, 8'h8f);
    put(SLC_OFS_SHSEL, 8'h02);
    chk({7'h0, refd_seen}, 8'h01);
    @(posedge clk) lnk <= 0;
    cal <= 1;
    put(SLC_OFS_CHEN, 8'h01);
    chk({refd_seen, 3'h0, chan}, 8'h8f);
    @(posedge clk) cal <= 0;
  endtask
  task automatic t_hdr();
    logic [1:0] e [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    @(posedge clk) fmt <= 1;
    for (int i = 0; i < 4; i++) begin
      put(SLC_OFS_SHSEL, 8'(i));
      chk({6'h0, hdr}, {6'h0, e[i]});
      chk(sbits, 8'h20);
    end
    @(posedge clk) fmt <= 0;
    put(SLC_OFS_SHSEL, 8'h02);
    chk({sbits[7:2], hdr}, 8'h00);
  endtask
  // Short low pulse is ignored, a long one requests resync on time
  task automatic t_sync();
    logic seen;
    put(SLC_OFS_THRESH, 8'h02);
    seen = 1'b0;
    @(posedge clk) sync_n <= 0;
    repeat (2) @(posedge clk);
    sync_n <= 1;
    // Watch every cycle so a brief false request is not missed
    repeat (8) begin
      @(posedge clk) #1;
      seen = seen | rq;
    end
    chk({7'h0, seen}, 8'h00);
    @(posedge clk) sync_n <= 0;
    repeat (4) @(posedge clk);
    #1 chk({7'h0, rq}, 8'h00);
    @(posedge clk);
    #1 chk({7'h0, rq}, 8'h01);
    @(posedge clk) sync_n <= 1;
    repeat (3) @(posedge clk);
    #1 chk({7'h0, rq}, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_pairs();
    t_freeze();
    t_guard();
    t_hdr();
    t_sync();
    report_and_stop();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule
